// >>> hdl/cccs_pkg.sv
// What this block does
// RL1 - The call occupies two words and two cycles: it takes the low target bits, pushes the return address, then takes the high target bits and writes the program counter, and its second cycle does nothing.
// RL2 - After a call the program counter holds the target and the stack top holds the call address plus four.
// RL3 - A call with the shadow bit set copies accumulator, flags and bank select into their shadows, otherwise the shadows stay untouched.
// RL4 - The call loads its 20-bit literal into program counter bits 20 down to 1.
// RL5 - Clear-register writes zero to the addressed location and sets the zero flag in one word and one cycle.
// RL6 - Watchdog-clear zeroes the watchdog counter and postscaler and sets the expired and sleep flags without touching data.
// RL7 - Complement-register writes the inverse of the operand and changes only the negative and zero flags.
// RL8 - The destination bit sends the result back to the register when one and to the accumulator when zero.
// RL9 - With the bank bit zero the operand addresses the access bank.
// RL10 - With the bank bit one the address is the bank select register joined to the operand.
// RL11 - With the extended set on and the bank bit zero, operands up to 5Fh are offsets from the index register.
// RL12 - Compare-skip-equal stores nothing, changes no flag and discards the prefetched word on equality.
// RL13 - Compare-skip-greater discards the prefetched word only when the operand exceeds the accumulator.
// RL14 - Compare-skip-less discards the prefetched word only when the operand is below the accumulator.
// RL15 - A compare takes one cycle without skip, two when skipping a one-word and three when skipping a two-word instruction.
// RL16 - Each cycle decodes in the first quarter, reads in the second, computes in the third and writes in the fourth.
`default_nettype none
package cccs_pkg;
  localparam int PC_W = 21;
  localparam int ADDR_W = 12;
  localparam int BANK_W = 4;
  localparam logic [6:0] OP_CLEAR = 7'h35;
  localparam logic [5:0] OP_COMPL = 6'h07;
  localparam logic [6:0] OP_CMP_EQ = 7'h31;
  localparam logic [6:0] OP_CMP_GT = 7'h32;
  localparam logic [6:0] OP_CMP_LT = 7'h30;
  localparam logic [6:0] OP_CALL = 7'h76;
  localparam logic [15:0] OP_WATCHDOG_CLEAR = 16'h0004;
  localparam logic [3:0] OP_MOVE_FF = 4'hc;
  localparam logic [7:0] OP_GOTO = 8'hef;
  localparam logic [7:0] OP_LOAD_FSR = 8'hee;
  localparam logic [15:0] NOP_WORD = 16'h0000;
  localparam int BIT_BANK = 8;
  localparam int BIT_DEST = 9;
  localparam int BIT_SHADOW = 8;
  localparam int FLAG_N = 4;
  localparam int FLAG_Z = 2;
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [3:0] ACCESS_LOW = 4'h0;
  localparam logic [3:0] ACCESS_HIGH = 4'hf;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] RESET_PC = 21'h000000;
  localparam logic [7:0] RESET_FLAGS = 8'h00;
  localparam logic [7:0] CLEAR_VALUE = 8'h00;
  localparam logic RESET_WATCHDOG_FLAG = 1'b1;
  typedef enum logic [1:0] {ph_q1, ph_q2, ph_q3, ph_q4} phase_t;
endpackage
`default_nettype wire

// >>> hdl/call_clear_complement_compare_skip.sv
`timescale 1ns/100ps
`default_nettype none
module call_clear_complement_compare_skip (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [15:0] instr_in,
  input wire logic [7:0] rdata_in,
  input wire logic ext_set_in,
  input wire logic [cccs_pkg::ADDR_W-1:0] index_base_in,
  input wire logic preload_in,
  input wire logic [7:0] preload_acc_in,
  input wire logic [7:0] preload_flags_in,
  input wire logic [cccs_pkg::BANK_W-1:0] preload_bank_in,
  output logic [cccs_pkg::PC_W-1:0] pc_out,
  output logic [1:0] phase_out,
  output logic discard_out,
  output logic [cccs_pkg::ADDR_W-1:0] addr_out,
  output logic [7:0] wdata_out,
  output logic we_out,
  output logic [7:0] accumulator_out,
  output logic [7:0] flags_out,
  output logic [cccs_pkg::BANK_W-1:0] bank_select_out,
  output logic [7:0] accumulator_shadow_out,
  output logic [7:0] flags_shadow_out,
  output logic [cccs_pkg::BANK_W-1:0] bank_select_shadow_out,
  output logic [cccs_pkg::PC_W-1:0] stack_top_out,
  output logic stack_push_out,
  output logic watchdog_clear_out,
  output logic watchdog_expired_flag_out,
  output logic sleep_flag_out
);
  import cccs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Registers and decode.

  phase_t phase;
  phase_t next_phase;
  logic [15:0] ir;
  logic discard;
  logic discard_tail;
  logic [7:0] klow;
  logic [7:0] operand;
  logic [7:0] result;
  logic skip;
  logic [PC_W-1:0] pc;
  logic [7:0] accumulator_reg;
  logic [7:0] flags;
  logic [BANK_W-1:0] bank_select_reg;
  logic [7:0] accumulator_shadow;
  logic [7:0] flags_shadow;
  logic [BANK_W-1:0] bank_select_shadow;
  logic [PC_W-1:0] stack_top;
  logic stack_push;
  logic watchdog_clear;
  logic watchdog_expired_flag;
  logic sleep_flag;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic we;

  function automatic logic is_two_word(input logic [15:0] w);
    is_two_word = (w[15:12] == OP_MOVE_FF) || (w[15:8] == OP_GOTO) ||
                  (w[15:8] == OP_LOAD_FSR) || (w[15:9] == OP_CALL);
  endfunction

  wire valid = !discard;
  wire [7:0] f = ir[7:0];
  wire clear_register_op = valid && (ir[15:9] == OP_CLEAR);
  wire complement_register_op = valid && (ir[15:10] == OP_COMPL);
  wire compare_skip_equal_op = valid && (ir[15:9] == OP_CMP_EQ);
  wire compare_skip_greater_op = valid && (ir[15:9] == OP_CMP_GT);
  wire compare_skip_less_op = valid && (ir[15:9] == OP_CMP_LT);
  wire watchdog_clear_op = valid && (ir == OP_WATCHDOG_CLEAR);
  wire call_op = valid && (ir[15:9] == OP_CALL);
  wire compare_op = compare_skip_equal_op || compare_skip_greater_op || compare_skip_less_op;
  wire to_register = ir[BIT_DEST];
  wire use_bank = ir[BIT_BANK];
  wire use_shadow = ir[BIT_SHADOW];

  ////////////////////////////////////////////////////////////////////////
  // Data address and operation results.

  wire indexed = ext_set_in && (f <= INDEX_LIMIT); // RL11
  wire [ADDR_W-1:0] index_addr = index_base_in + {4'h0, f}; // RL11
  wire [ADDR_W-1:0] bank_addr = {bank_select_reg, f}; // RL10
  wire [ADDR_W-1:0] access_addr = (f > INDEX_LIMIT) ? {ACCESS_HIGH, f} : {ACCESS_LOW, f}; // RL9
  wire [ADDR_W-1:0] next_addr = use_bank ? bank_addr : (indexed ? index_addr : access_addr);
  wire is_equal = operand == accumulator_reg; // RL12
  wire is_greater = operand > accumulator_reg; // RL13
  wire is_less = operand < accumulator_reg; // RL14
  wire next_skip = (compare_skip_equal_op && is_equal) || (compare_skip_greater_op && is_greater) ||
                   (compare_skip_less_op && is_less);
  wire [7:0] next_result = clear_register_op ? CLEAR_VALUE : ~operand; // RL5 RL7
  wire next_we = clear_register_op || (complement_register_op && to_register); // RL8
  wire [PC_W-1:0] call_target = {instr_in[11:0], klow, 1'b0}; // RL4

  always_comb begin
    case (phase)
      ph_q1: next_phase = ph_q2;
      ph_q2: next_phase = ph_q3;
      ph_q3: next_phase = ph_q4;
      ph_q4: next_phase = ph_q1;
      default: next_phase = ph_q1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Quarter-cycle sequencing.

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      phase <= ph_q1;
    end else begin
      phase <= next_phase; // RL16
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      addr <= '0;
      operand <= 8'h00;
      klow <= 8'h00;
    end else if (phase == ph_q1) begin
      addr <= next_addr; // RL16
    end else if (phase == ph_q2) begin
      operand <= rdata_in; // RL16
      klow <= ir[7:0]; // RL1
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      result <= 8'h00;
      wdata <= 8'h00;
      we <= 1'b0;
      skip <= 1'b0;
      watchdog_clear <= 1'b0;
    end else begin
      if (phase == ph_q3) begin
        result <= next_result;
        wdata <= next_result;
        we <= next_we; // RL16
        skip <= next_skip;
        watchdog_clear <= watchdog_clear_op; // RL6
      end else begin
        we <= 1'b0;
        watchdog_clear <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter, prefetch and discard of skipped words.

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pc <= RESET_PC;
      ir <= NOP_WORD;
      discard <= 1'b0;
      discard_tail <= 1'b0;
    end else if (phase == ph_q4) begin
      ir <= instr_in;
      if (call_op) begin
        pc <= call_target; // RL1 RL4
      end else begin
        pc <= pc + PC_STEP;
      end
      discard <= call_op || skip || discard_tail; // RL1 RL12 RL15
      discard_tail <= skip && is_two_word(instr_in); // RL15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Return stack and shadow registers.

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stack_top <= RESET_PC;
      stack_push <= 1'b0;
      accumulator_shadow <= 8'h00;
      flags_shadow <= RESET_FLAGS;
      bank_select_shadow <= '0;
    end else if (phase == ph_q3 && call_op) begin
      stack_top <= pc + PC_STEP; // RL2
      stack_push <= 1'b1; // RL1
      if (use_shadow) begin
        accumulator_shadow <= accumulator_reg; // RL3
        flags_shadow <= flags; // RL3
        bank_select_shadow <= bank_select_reg; // RL3
      end
    end else begin
      stack_push <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Accumulator, flags and watchdog status.

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      accumulator_reg <= 8'h00;
      flags <= RESET_FLAGS;
      bank_select_reg <= '0;
    end else begin
      if (preload_in) begin
        accumulator_reg <= preload_acc_in;
        flags <= preload_flags_in;
        bank_select_reg <= preload_bank_in;
      end
      if (phase == ph_q4 && complement_register_op) begin
        if (!to_register) begin
          accumulator_reg <= result; // RL8
        end
        flags[FLAG_N] <= result[7]; // RL7
        flags[FLAG_Z] <= result == 8'h00; // RL7
      end
      if (phase == ph_q4 && clear_register_op) begin
        flags[FLAG_Z] <= 1'b1; // RL5
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      watchdog_expired_flag <= RESET_WATCHDOG_FLAG;
      sleep_flag <= RESET_WATCHDOG_FLAG;
    end else if (phase == ph_q4 && watchdog_clear_op) begin
      watchdog_expired_flag <= 1'b1; // RL6
      sleep_flag <= 1'b1; // RL6
    end
  end

  assign pc_out = pc;
  assign phase_out = phase;
  assign discard_out = discard;
  assign addr_out = addr;
  assign wdata_out = wdata;
  assign we_out = we;
  assign accumulator_out = accumulator_reg;
  assign flags_out = flags;
  assign bank_select_out = bank_select_reg;
  assign accumulator_shadow_out = accumulator_shadow;
  assign flags_shadow_out = flags_shadow;
  assign bank_select_shadow_out = bank_select_shadow;
  assign stack_top_out = stack_top;
  assign stack_push_out = stack_push;
  assign watchdog_clear_out = watchdog_clear;
  assign watchdog_expired_flag_out = watchdog_expired_flag;
  assign sleep_flag_out = sleep_flag;

  ////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_phase_order_seq: assert property ((phase == ph_q1) |=> (phase == ph_q2) ##1 (phase == ph_q3) ##1 (phase == ph_q4)) // RL16
    else $error("quarter phases out of order");
  a_call_target_pc: assert property ((phase == ph_q4 && call_op) |=> (pc == $past(call_target)) && discard) // RL1 RL4
    else $error("call target or second cycle wrong");
  a_call_return_addr: assert property ((phase == ph_q3 && call_op) |=> stack_push && (stack_top == $past(pc) + PC_STEP)) // RL2
    else $error("return address wrong");
  a_shadow_copy_set: assert property ((phase == ph_q3 && call_op && use_shadow) |=> (accumulator_shadow == $past(accumulator_reg)) && (flags_shadow == $past(flags))) // RL3
    else $error("shadow copy missing");
  a_shadow_keep_clear: assert property ((phase == ph_q3 && call_op && !use_shadow) |=> $stable(accumulator_shadow) && $stable(bank_select_shadow)) // RL3
    else $error("shadow changed");
  a_clear_write_zero: assert property ((phase == ph_q3 && clear_register_op) |=> we && (wdata == CLEAR_VALUE) ##1 flags[FLAG_Z]) // RL5
    else $error("clear register wrong");
  a_watchdog_clear_flags: assert property ((phase == ph_q3 && watchdog_clear_op) |=> watchdog_clear && !we ##1 watchdog_expired_flag && sleep_flag) // RL6
    else $error("watchdog clear wrong");
  a_compl_to_acc: assert property ((phase == ph_q3 && complement_register_op && !to_register && !preload_in) |=> !we ##1 (accumulator_reg == ~$past(operand, 2))) // RL7 RL8
    else $error("complement to accumulator wrong");
  a_bank_addr_form: assert property ((phase == ph_q1 && use_bank) |=> (addr == {$past(bank_select_reg), $past(f)})) // RL10
    else $error("banked address wrong");
  a_access_addr_form: assert property ((phase == ph_q1 && !use_bank && !ext_set_in) |=> (addr[7:0] == $past(f))) // RL9 RL11
    else $error("access address wrong");
  a_skip_discards_word: assert property ((phase == ph_q3 && next_skip) |=> ##1 discard) // RL12 RL13 RL14 RL15
    else $error("skip did not discard");
  a_no_skip_keeps: assert property ((phase == ph_q3 && compare_op && !next_skip && !discard_tail) |=> ##1 !discard) // RL15
    else $error("compare discarded without skip");
  a_compare_no_write: assert property ((phase == ph_q3 && compare_op) |=> !we) // RL12
    else $error("compare wrote data");
  a_stack_push_pulse: assert property (stack_push |=> !stack_push) // RL1
    else $error("stack push longer than one clock");
  a_watchdog_clear_pulse: assert property (watchdog_clear |=> !watchdog_clear) // RL6
    else $error("watchdog clear longer than one clock");
  a_discard_no_effect: assert property (discard |-> !we && !stack_push && !watchdog_clear) // RL12 RL15
    else $error("discarded word had an effect");
  a_two_word_tail: assert property ((phase == ph_q4 && skip && is_two_word(instr_in)) |=> ##4 discard) // RL15
    else $error("second word of skipped instruction not discarded");
  a_compl_flags_set: assert property ((phase == ph_q4 && complement_register_op) |=> // RL7
    (flags[FLAG_N] == !$past(operand[7])) && (flags[FLAG_Z] == ($past(~operand) == CLEAR_VALUE)))
    else $error("complement flags wrong");

  c_call_shadow: cover property (phase == ph_q3 && call_op && use_shadow);
  c_skip_two_word: cover property (phase == ph_q4 && skip && is_two_word(instr_in));
  c_compl_to_reg: cover property (phase == ph_q3 && complement_register_op && to_register);
  c_indexed_access: cover property (phase == ph_q1 && !use_bank && indexed);
  c_watchdog_clear: cover property (phase == ph_q3 && watchdog_clear_op);
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module tb_top;
  import cccs_pkg::*;
  logic clk_in, nrst_in, ext_set_in, preload_in, discard_out, we_out, stack_push_out;
  logic watchdog_clear_out, watchdog_expired_flag_out, sleep_flag_out, push_seen;
  logic [15:0] instr_in;
  logic [7:0] rdata_in, preload_acc_in, preload_flags_in, wdata_out, accumulator_out, flags_out;
  logic [7:0] accumulator_shadow_out, flags_shadow_out;
  logic [ADDR_W-1:0] index_base_in, addr_out;
  logic [BANK_W-1:0] preload_bank_in, bank_select_out, bank_select_shadow_out;
  logic [PC_W-1:0] pc_out, stack_top_out;
  logic [1:0] phase_out;
  logic [15:0] prog [32];
  logic [7:0] dmem [4096];
  logic [PC_W-1:0] top_q [$];
  logic [PC_W-1:0] pc_q [$];
  int miscompares = 0;
  int total_checks = 0;
  int disc_cnt, watchdog_cnt;

  call_clear_complement_compare_skip uut (.clk_in(clk_in), .nrst_in(nrst_in), .instr_in(instr_in),
    .rdata_in(rdata_in), .ext_set_in(ext_set_in), .index_base_in(index_base_in), .preload_in(preload_in),
    .preload_acc_in(preload_acc_in), .preload_flags_in(preload_flags_in), .preload_bank_in(preload_bank_in),
    .pc_out(pc_out), .phase_out(phase_out), .discard_out(discard_out), .addr_out(addr_out),
    .wdata_out(wdata_out), .we_out(we_out), .accumulator_out(accumulator_out), .flags_out(flags_out),
    .bank_select_out(bank_select_out), .accumulator_shadow_out(accumulator_shadow_out),
    .flags_shadow_out(flags_shadow_out), .bank_select_shadow_out(bank_select_shadow_out),
    .stack_top_out(stack_top_out), .stack_push_out(stack_push_out), .watchdog_clear_out(watchdog_clear_out),
    .watchdog_expired_flag_out(watchdog_expired_flag_out), .sleep_flag_out(sleep_flag_out));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, program memory, data memory and monitors.
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (we_out === 1'b1) dmem[addr_out] <= wdata_out;
    if (discard_out === 1'b1) disc_cnt++;
  end

  always @(negedge clk_in) begin
    instr_in <= prog[pc_out[5:1]];
    rdata_in <= dmem[addr_out];
    if (we_out === 1'b1) `CHECK(phase_out, 2'h3)
    if (watchdog_clear_out === 1'b1) watchdog_cnt++;
    if (push_seen) pc_q.push_back(pc_out);
    push_seen = (stack_push_out === 1'b1);
    if (push_seen) top_q.push_back(stack_top_out);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Tasks that clear the memories, reset the core, run it and report the result.
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic clear_mem();
    foreach (prog[i]) prog[i] = NOP_WORD;
    foreach (dmem[i]) dmem[i] = 8'haa;
  endtask

  task automatic do_reset(input logic [7:0] acc, input logic [7:0] flg, input logic [3:0] bank, input logic ext);
    nrst_in = 1'b0;
    preload_in = 1'b1;
    preload_acc_in = acc;
    preload_flags_in = flg;
    preload_bank_in = bank;
    ext_set_in = ext;
    repeat (12) @(negedge clk_in);
    `CHECK({watchdog_expired_flag_out, sleep_flag_out, phase_out}, 4'hc)
    disc_cnt = 0;
    watchdog_cnt = 0;
    top_q.delete();
    pc_q.delete();
    push_seen = 1'b0;
    nrst_in = 1'b1;
    @(negedge clk_in);
    preload_in = 1'b0;
    `CHECK(phase_out, 2'h1)
  endtask

  task automatic run_to(input logic [PC_W-1:0] target);
    int n;
    n = 0;
    while (pc_out !== target && n < 400) begin
      @(negedge clk_in);
      n++;
    end
    if (n >= 400) begin
      miscompares++;
      $display("unexpected at %0t ns: got %h expected %h", $time, pc_out, target);
      end_of_test();
    end
    repeat (8) @(negedge clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Test sequence.
  initial begin
    nrst_in = 1'b0;
    instr_in = NOP_WORD;
    rdata_in = 8'h00;
    index_base_in = 12'h100;
    clear_mem();
    prog[0] = 16'h6b10; prog[1] = 16'h1f20; prog[2] = 16'h1c21; prog[3] = 16'h1e80;
    dmem[12'h310] = 8'h5a; dmem[12'h320] = 8'h13; dmem[12'h021] = 8'h13; dmem[12'hf80] = 8'hff;
    do_reset(8'h00, 8'h00, 4'h3, 1'b0);
    run_to(21'h00000a);
    `CHECK(dmem[12'h310], 8'h00)
    `CHECK(dmem[12'h320], 8'hec)
    `CHECK(accumulator_out, 8'hec)
    `CHECK(dmem[12'h021], 8'h13)
    `CHECK(dmem[12'hf80], 8'h00)
    `CHECK(flags_out, 8'h04)
    $display("test clear_complement finished");
    clear_mem();
    prog[0] = 16'h6a05; prog[1] = 16'h6a60; prog[2] = 16'h6b07;
    do_reset(8'h00, 8'h00, 4'h2, 1'b1);
    run_to(21'h00000a);
    `CHECK(dmem[12'h105], 8'h00)
    `CHECK(dmem[12'h005], 8'haa)
    `CHECK(dmem[12'hf60], 8'h00)
    `CHECK(dmem[12'h207], 8'h00)
    $display("test addressing finished");
    clear_mem();
    prog[0] = 16'h6230; prog[1] = 16'h6a40; prog[2] = 16'h6431; prog[3] = 16'h6a41; prog[4] = 16'h6032;
    prog[5] = 16'h6a42; prog[6] = 16'h6033; prog[7] = 16'hef00; prog[8] = 16'hf000; prog[9] = 16'h6a43;
    dmem[12'h030] = 8'h50; dmem[12'h031] = 8'h51; dmem[12'h032] = 8'h50; dmem[12'h033] = 8'h4f;
    do_reset(8'h50, 8'h1b, 4'h0, 1'b0);
    run_to(21'h000016);
    `CHECK(dmem[12'h040], 8'haa)
    `CHECK(dmem[12'h041], 8'haa)
    `CHECK(dmem[12'h042], 8'h00)
    `CHECK(dmem[12'h043], 8'h00)
    `CHECK(disc_cnt, 16)
    `CHECK(flags_out, 8'h1f)
    `CHECK(dmem[12'h030], 8'h50)
    `CHECK(accumulator_out, 8'h50)
    $display("test compare_skip finished");
    clear_mem();
    prog[0] = 16'hed45; prog[1] = 16'hf123; prog[5] = OP_WATCHDOG_CLEAR; prog[6] = 16'h1c22;
    prog[7] = 16'hec10; prog[8] = 16'hf000;
    dmem[12'h022] = 8'h33;
    do_reset(8'h5a, 8'h11, 4'h7, 1'b0);
    run_to(21'h000022);
    `CHECK(top_q[0], 21'h000004)
    `CHECK(pc_q[0], 21'h02468a)
    `CHECK(top_q[1], 21'h024692)
    `CHECK(pc_q[1], 21'h000020)
    `CHECK({accumulator_shadow_out, flags_shadow_out, bank_select_shadow_out}, 20'h5a117)
    `CHECK(bank_select_out, 4'h7)
    `CHECK(disc_cnt, 8)
    `CHECK(watchdog_cnt, 1)
    `CHECK({watchdog_expired_flag_out, sleep_flag_out}, 2'h3)
    `CHECK(accumulator_out, 8'hcc)
    `CHECK(flags_out, 8'h11)
    $display("test call_watchdog finished");
    end_of_test();
  end
endmodule
`default_nettype wire
